// [cise_core.sv]
`timescale 1ns/10ps
`default_nettype none
module cise_core (
  input  wire logic        sys_clk_i,      // core clock, 10 MHz
  input  wire logic        nrst_i,         // async reset, active low
  input  wire logic        hsel_i,         // ahb slave select
  input  wire logic [31:0] haddr_i,        // ahb address
  input  wire logic [1:0]  htrans_i,       // ahb transfer type
  input  wire logic        hwrite_i,       // ahb write
  input  wire logic [2:0]  hsize_i,        // ahb size, word only
  input  wire logic [31:0] hwdata_i,       // ahb write data
  input  wire logic        hready_i,       // ahb bus ready
  output logic      [31:0] hrdata_o,       // ahb read data
  output logic             hreadyout_o,    // ahb slave ready
  output logic             hresp_o,        // ahb response
  input  wire logic [15:0] instr_i,        // instruction word
  input  wire logic        instr_valid_i,  // instruction word present
  output logic             instr_ready_o,  // word taken this cycle
  output logic      [15:0] pc_o,           // program counter
  output logic      [7:0]  acc_o           // accumulator
);
  import cise_pkg::*;

  // ****************************************
  // storage
  // ****************************************
  cise_state_t state_r;
  cise_state_t state_nxt;
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [7:0]  acc_r;
  logic [7:0]  acc_nxt;
  logic [4:0]  flags_r;
  logic [4:0]  flags_nxt;
  logic [7:0]  bank_r;
  logic [7:0]  bank_nxt;
  logic        run_r;
  logic        run_nxt;
  logic [11:0] src_r;
  logic [11:0] src_nxt;
  logic [11:0] memaddr_r;
  logic [11:0] memaddr_nxt;
  logic        wr_pend_r;
  logic [7:0]  wr_ofs_r;
  logic [31:0] hrdata_r;

  cise_dp_if dp ();

  cise_alu u_alu (
    .dp (dp.alu)
  );

  cise_dmem u_dmem (
    .sys_clk_i (sys_clk_i),
    .dp        (dp.mem)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [11:0] file_addr(input logic use_bank,
                                            input logic [7:0] f,
                                            input logic [7:0] bank);
    logic [11:0] a;
    if (use_bank) begin
      a = {bank[3:0], f};
    end else if (f < ACCESS_SPLIT) begin
      a = {4'h0, f};
    end else begin
      a = {ACCESS_HI_BNK, f};
    end
    return a;
  endfunction

  function automatic logic over_nine(input logic [3:0] n);
    return n > BCD_MAX;
  endfunction

  // ****************************************
  // bus slave
  // ****************************************
  logic        ahb_take;
  logic        bus_we;
  logic [31:0] rd_val;

  assign ahb_take    = hsel_i & htrans_i[1] & hready_i;
  assign bus_we      = wr_pend_r;
  // zero wait states: every transfer completes in its first data cycle
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_r;

  always_comb begin
    if (haddr_i[7:0] == OFS_CTRL) begin
      rd_val = {31'h0, run_r};
    end else if (haddr_i[7:0] == OFS_ACC) begin
      rd_val = {24'h0, acc_r};
    end else if (haddr_i[7:0] == OFS_FLAGS) begin
      rd_val = {27'h0, flags_r};
    end else if (haddr_i[7:0] == OFS_PC) begin
      rd_val = {16'h0, pc_r};
    end else if (haddr_i[7:0] == OFS_BANK) begin
      rd_val = {24'h0, bank_r};
    end else if (haddr_i[7:0] == OFS_MEMADDR) begin
      rd_val = {20'h0, memaddr_r};
    end else if (haddr_i[7:0] == OFS_MEMDATA) begin
      rd_val = {24'h0, dp.mem_rdata_b};
    end else begin
      rd_val = 32'h0;
    end
  end

  logic wsel_ctrl;
  logic wsel_acc;
  logic wsel_flags;
  logic wsel_bank;
  logic wsel_maddr;
  logic wsel_mdata;

  assign wsel_ctrl  = bus_we & (wr_ofs_r == OFS_CTRL);
  assign wsel_acc   = bus_we & (wr_ofs_r == OFS_ACC);
  assign wsel_flags = bus_we & (wr_ofs_r == OFS_FLAGS);
  assign wsel_bank  = bus_we & (wr_ofs_r == OFS_BANK);
  assign wsel_maddr = bus_we & (wr_ofs_r == OFS_MEMADDR);
  assign wsel_mdata = bus_we & (wr_ofs_r == OFS_MEMDATA);

  // ****************************************
  // instruction decode
  // ****************************************
  logic        fire;
  logic        in_exec;
  logic        is_add_k;
  logic        is_add_f;
  logic        is_dec_f;
  logic        is_bcd_adj;
  logic        is_br_nw;
  logic        is_br_nz;
  logic        is_mov1;
  logic        is_mov2;
  logic        br_taken;
  logic [11:0] f_addr;
  logic [7:0]  file_val;
  logic [15:0] br_off;
  logic        adj_lo;
  logic        adj_hi;

  // a pending bus write owns the accumulator and memory port, so the core waits
  assign instr_ready_o = run_r & ~wr_pend_r & (state_r != CISE_BR_IDLE);
  assign fire          = instr_ready_o & instr_valid_i;
  assign in_exec       = state_r == CISE_EXEC;

  assign is_add_k   = in_exec & (instr_i[15:8] == OPC_ADD_LITERAL);
  assign is_add_f   = in_exec & (instr_i[15:10] == OPC_ADD_FILE);
  assign is_dec_f   = in_exec & (instr_i[15:10] == OPC_DEC_FILE);
  assign is_bcd_adj = in_exec & (instr_i == OPC_DEC_ADJUST);
  assign is_br_nw   = in_exec & (instr_i[15:8] == OPC_BR_NO_OVF);
  assign is_br_nz   = in_exec & (instr_i[15:8] == OPC_BR_NONZERO);
  assign is_mov1  = in_exec & (instr_i[15:12] == OPC_MOVE_FIRST);
  assign is_mov2  = (state_r == CISE_MOVE_DST) & (instr_i[15:12] == OPC_MOVE_SECOND);

  assign f_addr = file_addr(instr_i[8], instr_i[7:0], bank_r);

  // move source uses the full 12-bit address, no banking
  assign dp.mem_raddr_a = (state_r == CISE_MOVE_DST) ? src_r : f_addr;
  assign dp.mem_raddr_b = memaddr_r;
  assign file_val = (dp.mem_raddr_a == LOC_ACC) ? acc_r : dp.mem_rdata_a;

  assign br_taken = is_br_nw ? ~flags_r[FL_WRAP] : ~flags_r[FL_Z];
  assign br_off   = {{7{instr_i[7]}}, instr_i[7:0], 1'b0};

  assign adj_lo = over_nine(acc_r[3:0]) | flags_r[FL_NIB];
  assign adj_hi = over_nine(acc_r[7:4]) | flags_r[FL_C];

  assign dp.alu_a   = is_dec_f ? file_val : acc_r;
  assign dp.alu_cin = is_dec_f;
  assign dp.alu_b   = is_dec_f   ? DEC_ADDEND :
                      is_bcd_adj ? {adj_hi ? BCD_ADJ : 4'h0, adj_lo ? BCD_ADJ : 4'h0} :
                      is_add_k   ? instr_i[7:0] : file_val;

  // ****************************************
  // execution
  // ****************************************
  logic        core_we;
  logic [11:0] core_waddr;
  logic [7:0]  core_wdata;

  always_comb begin
    state_nxt   = state_r;
    pc_nxt      = pc_r;
    acc_nxt     = acc_r;
    flags_nxt   = flags_r;
    src_nxt     = src_r;
    core_we     = 1'b0;
    core_waddr  = f_addr;
    core_wdata  = dp.alu_res;
    case (state_r)
      CISE_BR_IDLE: begin
        state_nxt = CISE_EXEC;
      end
      CISE_MOVE_DST: begin
        if (fire) begin
          pc_nxt    = pc_r + BR_STEP;
          state_nxt = CISE_EXEC;
          if (is_mov2) begin
            core_waddr = instr_i[11:0];
            core_wdata = file_val;
            if (instr_i[11:0] == LOC_ACC) begin
              acc_nxt = file_val;
            end else begin
              core_we = 1'b1;
            end
          end
        end
      end
      default: begin
        if (fire) begin
          pc_nxt = pc_r + BR_STEP;
          if (is_add_k) begin
            acc_nxt   = dp.alu_res;
            flags_nxt = dp.alu_flags;
          end else if (is_add_f || is_dec_f) begin
            flags_nxt = dp.alu_flags;
            if (!instr_i[9] || f_addr == LOC_ACC) begin
              acc_nxt = dp.alu_res;
            end else begin
              core_we = 1'b1;
            end
          end else if (is_bcd_adj) begin
            acc_nxt          = dp.alu_res;
            flags_nxt[FL_C]  = dp.alu_flags[FL_C] | flags_r[FL_C];
          end else if ((is_br_nw || is_br_nz) && br_taken) begin
            pc_nxt    = pc_r + BR_STEP + br_off;
            state_nxt = CISE_BR_IDLE;
          end else if (is_mov1) begin
            src_nxt   = instr_i[11:0];
            state_nxt = CISE_MOVE_DST;
          end
        end
      end
    endcase
    if (wsel_acc) begin
      acc_nxt = hwdata_i[7:0];
    end
    if (wsel_flags) begin
      flags_nxt = hwdata_i[4:0];
    end
  end

  assign run_nxt     = wsel_ctrl  ? hwdata_i[0]     : run_r;
  assign bank_nxt    = wsel_bank  ? hwdata_i[7:0]   : bank_r;
  assign memaddr_nxt = wsel_maddr ? hwdata_i[11:0]  : memaddr_r;

  // core writes cannot coincide with bus writes since the core stalls then
  assign dp.mem_we    = core_we | wsel_mdata;
  assign dp.mem_waddr = wsel_mdata ? memaddr_r : core_waddr;
  assign dp.mem_wdata = wsel_mdata ? hwdata_i[7:0] : core_wdata;

  assign pc_o  = pc_r;
  assign acc_o = acc_r;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r   <= CISE_EXEC;
      pc_r      <= RST_PC;
      acc_r     <= RST_ACC;
      flags_r   <= RST_FLAGS;
      src_r     <= RST_ADDR;
    end else begin
      state_r   <= state_nxt;
      pc_r      <= pc_nxt;
      acc_r     <= acc_nxt;
      flags_r   <= flags_nxt;
      src_r     <= src_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_r     <= RST_RUN;
      bank_r    <= RST_BANK;
      memaddr_r <= RST_ADDR;
    end else begin
      run_r     <= run_nxt;
      bank_r    <= bank_nxt;
      memaddr_r <= memaddr_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= 8'h00;
      hrdata_r  <= 32'h0;
    end else begin
      wr_pend_r <= ahb_take & hwrite_i;
      if (ahb_take) begin
        wr_ofs_r <= haddr_i[7:0];
      end
      if (ahb_take && !hwrite_i) begin
        hrdata_r <= rd_val;
      end
    end
  end

endmodule
`default_nettype wire

// [cise_pkg.sv]
`default_nettype none
package cise_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int PC_W   = 16;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int FL_W   = 5;

  // ****************************************
  // opcode fields
  // ****************************************
  localparam logic [7:0]  OPC_ADD_LITERAL  = 8'h0F;
  localparam logic [5:0]  OPC_ADD_FILE     = 6'h09;
  localparam logic [5:0]  OPC_DEC_FILE     = 6'h01;
  localparam logic [15:0] OPC_DEC_ADJUST   = 16'h0007;
  localparam logic [7:0]  OPC_BR_NO_OVF    = 8'hE5;
  localparam logic [7:0]  OPC_BR_NONZERO   = 8'hE1;
  localparam logic [3:0]  OPC_MOVE_FIRST   = 4'hC;
  localparam logic [3:0]  OPC_MOVE_SECOND  = 4'hF;

  // ****************************************
  // flag positions
  // ****************************************
  localparam int FL_C    = 0;
  localparam int FL_NIB  = 1;
  localparam int FL_Z    = 2;
  localparam int FL_WRAP = 3;
  localparam int FL_N    = 4;

  // ****************************************
  // data space locations
  // ****************************************
  localparam logic [11:0] LOC_ACC       = 12'hFE8;
  localparam logic [11:0] LOC_PC_LOW    = 12'hFF9;
  localparam logic [11:0] LOC_STACK_LOW = 12'hFFD;
  localparam logic [11:0] LOC_STACK_HI  = 12'hFFE;
  localparam logic [11:0] LOC_STACK_UP  = 12'hFFF;
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;
  localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;

  // ****************************************
  // arithmetic constants
  // ****************************************
  localparam logic [15:0] BR_STEP    = 16'h0002;
  localparam logic [7:0]  DEC_ADDEND = 8'hFE;
  localparam logic [3:0]  BCD_ADJ    = 4'h6;
  localparam logic [3:0]  BCD_MAX    = 4'h9;

  // ****************************************
  // register offsets and reset values
  // ****************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_ACC     = 8'h04;
  localparam logic [7:0] OFS_FLAGS   = 8'h08;
  localparam logic [7:0] OFS_PC      = 8'h0C;
  localparam logic [7:0] OFS_BANK    = 8'h10;
  localparam logic [7:0] OFS_MEMADDR = 8'h14;
  localparam logic [7:0] OFS_MEMDATA = 8'h18;

  localparam logic [15:0] RST_PC    = 16'h0000;
  localparam logic [7:0]  RST_ACC   = 8'h00;
  localparam logic [4:0]  RST_FLAGS = 5'h00;
  localparam logic [7:0]  RST_BANK  = 8'h00;
  localparam logic        RST_RUN   = 1'b0;
  localparam logic [11:0] RST_ADDR  = 12'h000;

  typedef enum logic [1:0] {
    CISE_EXEC,
    CISE_BR_IDLE,
    CISE_MOVE_DST
  } cise_state_t;

endpackage
`default_nettype wire

// [cise_dp_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface cise_dp_if;
  logic [7:0]  alu_a;
  logic [7:0]  alu_b;
  logic        alu_cin;
  logic [7:0]  alu_res;
  logic [4:0]  alu_flags;
  logic        mem_we;
  logic [11:0] mem_waddr;
  logic [7:0]  mem_wdata;
  logic [11:0] mem_raddr_a;
  logic [7:0]  mem_rdata_a;
  logic [11:0] mem_raddr_b;
  logic [7:0]  mem_rdata_b;

  modport core (output alu_a, alu_b, alu_cin, mem_we, mem_waddr, mem_wdata,
                output mem_raddr_a, mem_raddr_b,
                input alu_res, alu_flags, mem_rdata_a, mem_rdata_b);
  modport alu  (input alu_a, alu_b, alu_cin, output alu_res, alu_flags);
  modport mem  (input mem_we, mem_waddr, mem_wdata, mem_raddr_a, mem_raddr_b,
                output mem_rdata_a, mem_rdata_b);
endinterface
`default_nettype wire

// [cise_alu.sv]
`timescale 1ns/10ps
`default_nettype none
module cise_alu (
  cise_dp_if.alu dp  // operands in, sum and flags out
);
  import cise_pkg::*;

  logic [8:0] sum;
  logic [4:0] low;

  assign sum = {1'b0, dp.alu_a} + {1'b0, dp.alu_b} + {8'h00, dp.alu_cin};
  assign low = {1'b0, dp.alu_a[3:0]} + {1'b0, dp.alu_b[3:0]} + {4'h0, dp.alu_cin};
  assign dp.alu_res = sum[7:0];

  always_comb begin
    dp.alu_flags        = RST_FLAGS;
    dp.alu_flags[FL_C]    = sum[8];
    dp.alu_flags[FL_NIB]  = low[4];
    dp.alu_flags[FL_Z]    = (sum[7:0] == 8'h00);
    // signed wrap: like-signed operands giving an opposite-signed sum
    dp.alu_flags[FL_WRAP] = (dp.alu_a[7] == dp.alu_b[7]) && (sum[7] != dp.alu_a[7]);
    dp.alu_flags[FL_N]    = sum[7];
  end
endmodule
`default_nettype wire

// [cise_dmem.sv]
`timescale 1ns/10ps
`default_nettype none
module cise_dmem (
  input  wire logic sys_clk_i,  // core clock
  cise_dp_if.mem    dp          // one write port, two read ports
);
  import cise_pkg::*;

  // the data space is not reset; software initialises what it uses
  logic [7:0] mem [0:4095];

  always_ff @(posedge sys_clk_i) begin
    if (dp.mem_we) begin
      mem[dp.mem_waddr] <= dp.mem_wdata;
    end
  end

  assign dp.mem_rdata_a = mem[dp.mem_raddr_a];
  assign dp.mem_rdata_b = mem[dp.mem_raddr_b];
endmodule
`default_nettype wire

// [cise_core_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module cise_core_sva
  import cise_pkg::*;
(
  input wire logic        sys_clk_i,      // core clock
  input wire logic        nrst_i,         // async reset, active low
  input wire logic        hsel_i,         // ahb select
  input wire logic [1:0]  htrans_i,       // ahb transfer type
  input wire logic        hwrite_i,       // ahb write
  input wire logic        hready_i,       // ahb ready
  input wire logic [15:0] instr_i,        // instruction word
  input wire logic        instr_valid_i,  // word present
  input wire logic        instr_ready_o,  // word taken
  input wire logic [15:0] pc_o,           // program counter
  input wire logic [7:0]  acc_o           // accumulator
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  // ****************************************
  // flag shadow of the last literal add
  // ****************************************
  logic        lit_v_r;
  logic        z_r;
  logic        wrap_r;
  logic        mv_r;
  wire  [7:0]  op     = instr_i[15:8];
  wire  [7:0]  k      = instr_i[7:0];
  wire  [8:0]  sum    = {1'b0, acc_o} + {1'b0, k};
  wire         fire   = instr_valid_i && instr_ready_o;
  wire         lit    = fire && !mv_r && (op == OPC_ADD_LITERAL);
  wire         is_br  = fire && !mv_r && (op == OPC_BR_NO_OVF || op == OPC_BR_NONZERO);
  wire  [15:0] tgt    = pc_o + BR_STEP + {{7{k[7]}}, k, 1'b0};
  wire         bus_wr = hsel_i && htrans_i[1] && hready_i && hwrite_i;

  // the word after a move's first word is its destination, never an instruction
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mv_r <= 1'b0;
    end else if (fire) begin
      mv_r <= !mv_r && (op[7:4] == OPC_MOVE_FIRST);
    end
  end

  // a bus write may touch the flags, so the shadow is dropped then
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lit_v_r <= 1'b0;
      z_r     <= 1'b0;
      wrap_r  <= 1'b0;
    end else if (bus_wr) begin
      lit_v_r <= 1'b0;
    end else if (fire) begin
      lit_v_r <= lit;
      z_r     <= (sum[7:0] == 8'h00);
      wrap_r  <= (acc_o[7] == k[7]) && (sum[7] != acc_o[7]);
    end
  end

  // ****************************************
  // properties
  // ****************************************
  property p_lit_add;
    lit |=> acc_o == $past(sum[7:0]);
  endproperty
  a_lit_add: assert property (p_lit_add) else $error("literal add sum wrong");

  property p_br_nov;
    is_br && op == OPC_BR_NO_OVF && lit_v_r |=>
      pc_o == ($past(wrap_r) ? $past(pc_o) + BR_STEP : $past(tgt));
  endproperty
  a_br_nov: assert property (p_br_nov) else $error("overflow branch wrong");

  property p_br_nz;
    is_br && op == OPC_BR_NONZERO && lit_v_r |=>
      pc_o == ($past(z_r) ? $past(pc_o) + BR_STEP : $past(tgt));
  endproperty
  a_br_nz: assert property (p_br_nz) else $error("nonzero branch wrong");

  property p_br_target;
    is_br |=> pc_o == $past(pc_o) + BR_STEP || pc_o == $past(tgt);
  endproperty
  a_br_target: assert property (p_br_target) else $error("branch target wrong");

  property p_br_idle;
    is_br ##1 (pc_o != $past(pc_o) + BR_STEP) |-> !instr_ready_o ##1 $stable(pc_o);
  endproperty
  a_br_idle: assert property (p_br_idle) else $error("taken branch idle missing");

  property p_pc_hold;
    !fire |=> $stable(pc_o);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("pc moved without a word");

  property p_word_step;
    fire && !is_br |=> pc_o == $past(pc_o) + BR_STEP;
  endproperty
  a_word_step: assert property (p_word_step) else $error("pc step wrong");

  property p_br_acc;
    is_br |=> $stable(acc_o);
  endproperty
  a_br_acc: assert property (p_br_acc) else $error("branch changed acc");
endmodule

bind cise_core cise_core_sva chk_u (
  .sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i),
  .hsel_i(hsel_i),
  .htrans_i(htrans_i),
  .hwrite_i(hwrite_i),
  .hready_i(hready_i),
  .instr_i(instr_i),
  .instr_valid_i(instr_valid_i),
  .instr_ready_o(instr_ready_o),
  .pc_o(pc_o),
  .acc_o(acc_o)
);
`default_nettype wire

// [cise_core_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module cise_core_tb;
  import cise_pkg::*;
  logic        sys_clk_i;
  logic        nrst_i;
  logic        hsel_i;
  logic [31:0] haddr_i;
  logic [1:0]  htrans_i;
  logic        hwrite_i;
  logic [2:0]  hsize_i;
  logic [31:0] hwdata_i;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic [15:0] instr_i;
  logic        instr_valid_i;
  logic        instr_ready_o;
  logic [15:0] pc_o;
  logic [7:0]  acc_o;
  logic [15:0] epc;
  logic [31:0] rd;
  logic [31:0] ofs [8] = '{32'h00, 32'h04, 32'h08, 32'h0C, 32'h10, 32'h14, 32'h18, 32'h1C};
  logic [31:0] da  [4] = '{32'hA5000501, 32'hCE003401, 32'h19021F02, 32'h35019501};
  int          error_cnt;
  int          compares;

  cise_core dut_u (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
    .instr_ready_o(instr_ready_o), .pc_o(pc_o), .acc_o(acc_o)
  );

  always #50 sys_clk_i = ~sys_clk_i;

  // ****************************************
  // helpers
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // the trailing idle cycle lets a following read see this write
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    htrans_i <= 2'b10;
    haddr_i  <= a;
    hwrite_i <= wr;
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    check({30'h0, hreadyout_o, hresp_o}, 32'h2);
    @(posedge sys_clk_i);
  endtask

  task rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // a released word line shows the inverse so a late sample cannot match
  task step(input logic [15:0] w, input logic [15:0] dpc, input logic [7:0] eacc);
    instr_i       <= w;
    instr_valid_i <= 1'b1;
    do @(posedge sys_clk_i); while (instr_ready_o !== 1'b1);
    instr_valid_i <= 1'b0;
    instr_i       <= ~w;
    @(posedge sys_clk_i);
    epc = epc + dpc;
    check({16'h0, pc_o}, {16'h0, epc});
    check({24'h0, acc_o}, {24'h0, eacc});
  endtask

  task summarize;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge sys_clk_i);
    error_cnt++;
    summarize;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    sys_clk_i = 1'b0;
    nrst_i = 1'b0;
    hsel_i = 1'b1;
    haddr_i = 32'h0;
    htrans_i = 2'b00;
    hwrite_i = 1'b0;
    hsize_i = 3'b010;
    hwdata_i = 32'h0;
    instr_i = 16'h0;
    instr_valid_i = 1'b0;
    epc = 16'h0;
    error_cnt = 0;
    compares = 0;
    repeat (12) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    // data memory has no reset, so word 0 gets a value before the sweep reads it
    bus(1'b1, 32'h18, 32'h0);
    foreach (ofs[i]) rdchk(ofs[i], 32'h0);
    bus(1'b1, 32'h0C, 32'h1234);
    rdchk(32'h0C, 32'h0);
    $display("test reset done");
    bus(1'b1, 32'h04, 32'h10);
    bus(1'b1, 32'h00, 32'h1);
    step(16'h0F15, 16'h2, 8'h25);
    step(16'h0FDB, 16'h2, 8'h00);
    rdchk(32'h08, 32'h07);
    step(16'hE103, 16'h2, 8'h00);
    step(16'h0F7F, 16'h2, 8'h7F);
    step(16'h0F01, 16'h2, 8'h80);
    step(16'hE57F, 16'h2, 8'h80);
    step(16'hE103, 16'h8, 8'h80);
    step(16'h0F01, 16'h2, 8'h81);
    step(16'hE57F, 16'h100, 8'h81);
    step(16'hE180, 16'hFF02, 8'h81);
    $display("test branch done");
    bus(1'b1, 32'h14, 32'h005);
    bus(1'b1, 32'h18, 32'h40);
    bus(1'b1, 32'h14, 32'h210);
    bus(1'b1, 32'h18, 32'h03);
    bus(1'b1, 32'h14, 32'hF90);
    bus(1'b1, 32'h18, 32'h10);
    bus(1'b1, 32'h10, 32'h02);
    step(16'h2405, 16'h2, 8'hC1);
    step(16'h2605, 16'h2, 8'hC1);
    step(16'h0710, 16'h2, 8'hC1);
    rdchk(32'h08, 32'h03);
    step(16'h0490, 16'h2, 8'h0F);
    bus(1'b1, 32'h14, 32'h005);
    rdchk(32'h18, 32'h01);
    bus(1'b1, 32'h14, 32'h210);
    rdchk(32'h18, 32'h02);
    $display("test file ops done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 32'h04, {24'h0, da[i][31:24]});
      bus(1'b1, 32'h08, {24'h0, da[i][23:16]});
      step(16'h0007, 16'h2, da[i][15:8]);
      rdchk(32'h08, {24'h0, da[i][7:0]});
    end
    $display("test decimal adjust done");
    // move destinations stay clear of the pc and stack bytes
    step(16'hCF90, 16'h2, 8'h95);
    step(16'hF456, 16'h2, 8'h95);
    bus(1'b1, 32'h14, 32'h456);
    rdchk(32'h18, 32'h10);
    step(16'hCFE8, 16'h2, 8'h95);
    step(16'hF7FF, 16'h2, 8'h95);
    bus(1'b1, 32'h14, 32'h7FF);
    rdchk(32'h18, 32'h95);
    step(16'hCF90, 16'h2, 8'h95);
    step(16'hFFE8, 16'h2, 8'h10);
    step(16'hC456, 16'h2, 8'h10);
    step(16'h0F01, 16'h2, 8'h10);
    $display("test move done");
    summarize;
  end
endmodule
`default_nettype wire
